// ===== hdl/wrfs_pkg.sv
// Purpose: Constants and types of the working register file
// Assumes: One core clock, asynchronous active-low reset
// Notes: Shared by the register file and its loop shadow keeper
package wrfs_pkg;

   // ******************************************
   // Sizes and indices
   // ******************************************
   localparam int unsigned NUM_REGS = 16;
   localparam int unsigned CTX_REGS = 4;
   localparam int unsigned STATUS_W = 5;
   localparam logic [3:0] SP_IDX = 4'hF;
   localparam logic [3:0] FILE_IDX = 4'h0;

   // ******************************************
   // Reset values and addresses
   // ******************************************
   localparam logic [15:0] SP_RESET = 16'h0800;
   localparam logic [15:0] FILE_OPERAND_ALIAS_RESET = 16'h0000;
   localparam logic [15:0] FILE_OPERAND_ALIAS_BASE_ADDR = 16'h0000;
   localparam logic [15:0] WORKING_REGISTER_TWO_OFFSET = 16'h0004;

   // ******************************************
   // Saved flag positions
   // ******************************************
   localparam int unsigned FLG_DC = 0;
   localparam int unsigned FLG_C = 1;
   localparam int unsigned FLG_Z = 2;
   localparam int unsigned FLG_OV = 3;
   localparam int unsigned FLG_N = 4;

   typedef logic [15:0] wrfs_word_t;
   typedef enum logic {WRFS_DIRECT, WRFS_FILE} wrfs_sel_t;

   // Mapped window covers all sixteen registers
   function automatic logic wrfsMapHit(input logic [15:0] addr);
      return addr[15:5] == FILE_OPERAND_ALIAS_BASE_ADDR[15:5];
   endfunction

   function automatic wrfs_word_t wrfsLaneMerge(input wrfs_word_t old,
         input wrfs_word_t nw, input logic [1:0] be);
      return {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
   endfunction

endpackage

// ===== hdl/wrfs_loop_if.sv
// Purpose: Carries loop state between register file and loop shadow
// Assumes: Same clock as both modules
// Notes: keeper side owns the shadow flops
interface wrfs_loop_if;
   import wrfs_pkg::*;
   logic saveStb;
   logic restoreStb;
   wrfs_word_t curStart;
   wrfs_word_t curEnd;
   wrfs_word_t curCount;
   wrfs_word_t shStart;
   wrfs_word_t shEnd;
   wrfs_word_t shCount;
   logic restoreVld;
   modport keeper(input saveStb, restoreStb, curStart, curEnd, curCount,
      output shStart, shEnd, shCount, restoreVld);
   modport user(output saveStb, restoreStb, curStart, curEnd, curCount,
      input shStart, shEnd, shCount, restoreVld);
endinterface

// ===== hdl/wrfs_loop_shadow.sv
// Purpose: One-level shadow of loop start, end and count
// Assumes: Save and restore strobes are single-cycle pulses
// Notes: No instruction path reaches these flops
module wrfs_loop_shadow
   import wrfs_pkg::*;
(
   input wire logic mclk,
   input wire logic arst_n,
   wrfs_loop_if.keeper lp
);

   // ******************************************
   // Shadow copy
   // ******************************************
   // save on loop start
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         lp.shStart <= FILE_OPERAND_ALIAS_RESET;
         lp.shEnd <= FILE_OPERAND_ALIAS_RESET;
         lp.shCount <= FILE_OPERAND_ALIAS_RESET;
      end else if (lp.saveStb) begin
         lp.shStart <= lp.curStart;
         lp.shEnd <= lp.curEnd;
         lp.shCount <= lp.curCount;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         lp.restoreVld <= 1'b0;
      end else begin
         lp.restoreVld <= lp.restoreStb & ~lp.saveStb;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);

   a_loop_save_copy: assert property (
      lp.saveStb |=> lp.shCount == $past(lp.curCount)
         && lp.shStart == $past(lp.curStart)
         && lp.shEnd == $past(lp.curEnd))
      else $error("loop shadow did not capture");

   a_loop_hold_level: assert property (
      !lp.saveStb |=> $stable(lp.shCount) && $stable(lp.shStart))
      else $error("loop shadow changed without save");

endmodule

// ===== hdl/wrfs_regfile.sv
// Purpose: Working register array with shadows and init tracking
// Assumes: Decoder drives one-cycle requests on mclk
// Notes: Read data appears one edge after the request
module wrfs_regfile
   import wrfs_pkg::*;
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic [3:0] rdAddrA,
   input wire wrfs_sel_t rdSelA,
   input wire logic [3:0] rdAddrB,
   output logic [15:0] rdDataA_q,
   output logic [15:0] rdDataB_q,
   input wire logic wrEn,
   input wire wrfs_sel_t wrSel,
   input wire logic wrByte,
   input wire logic [3:0] wrAddr,
   input wire logic [15:0] wrData,
   input wire logic ptrUse,
   input wire logic [3:0] ptrAddr,
   input wire logic ptrUpdEn,
   input wire logic [15:0] ptrUpdData,
   output logic [15:0] ptrData_q,
   output logic uninitRst_q,
   input wire logic memEn,
   input wire logic memWe,
   input wire logic [15:0] memAddr,
   input wire logic [1:0] memBe,
   input wire logic [15:0] memWdata,
   output logic [15:0] memRdata_q,
   output logic memHit_q,
   input wire logic ctxSave,
   input wire logic ctxRestore,
   input wire logic [4:0] statusIn,
   output logic [4:0] statusOut_q,
   output logic statusLoad_q,
   input wire logic loopDoExec,
   input wire logic loopDoExit,
   input wire logic [15:0] loopStartAddrIn,
   input wire logic [15:0] loopEndAddrIn,
   input wire logic [15:0] loopIterCountIn,
   output logic [15:0] loopStartAddrSh,
   output logic [15:0] loopEndAddrSh,
   output logic [15:0] loopIterCountSh,
   output logic loopRestoreVld
);

   // ******************************************
   // Storage
   // ******************************************
   wrfs_word_t regs_q [NUM_REGS];
   wrfs_word_t regs_d [NUM_REGS];
   logic [NUM_REGS-1:0] init_q;
   logic [NUM_REGS-1:0] init_d;
   wrfs_word_t shW_q [CTX_REGS];
   logic [STATUS_W-1:0] shSt_q;

   logic [3:0] wrIdx;
   logic [3:0] rdIdxA;
   logic [3:0] memIdx;
   logic memHit;
   logic memWr;
   logic memWord;

   // ******************************************
   // Operand selection
   // ******************************************
   // file mode forces register zero
   assign wrIdx = (wrSel == WRFS_FILE) ? FILE_IDX : wrAddr;
   assign rdIdxA = (rdSelA == WRFS_FILE) ? FILE_IDX : rdAddrA;

   assign memHit = memEn & wrfsMapHit(memAddr);
   assign memIdx = memAddr[4:1];
   assign memWr = memHit & memWe & (memBe != 2'b00);
   assign memWord = memBe == 2'b11;

   // ******************************************
   // Next-state of the array
   // ******************************************
   // Later sources override earlier ones
   always_comb begin
      regs_d = regs_q;
      init_d = init_q;
      if (ptrUpdEn) begin
         regs_d[ptrAddr] = ptrUpdData;
         init_d[ptrAddr] = 1'b1;
      end
      if (ctxRestore) begin
         for (int i = 0; i < CTX_REGS; i++) begin
            regs_d[i] = shW_q[i];
            init_d[i] = 1'b1;
         end
      end
      if (wrEn) begin
         if (wrByte) begin
            regs_d[wrIdx] = {regs_d[wrIdx][15:8], wrData[7:0]};
         end else begin
            regs_d[wrIdx] = wrData;
            init_d[wrIdx] = 1'b1;
         end
      end
      if (memWr) begin
         // store lands last, beats pointer update
         regs_d[memIdx] = wrfsLaneMerge(regs_d[memIdx], memWdata, memBe);
         if (memWord) begin
            init_d[memIdx] = 1'b1;
         end
      end
      regs_d[SP_IDX][0] = 1'b0;
      // stack pointer never counts as uninitialized
      init_d[SP_IDX] = 1'b1;
   end

   // ******************************************
   // Array and init flops
   // ******************************************
   // reset values
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < NUM_REGS; i++) begin
            regs_q[i] <= (i == NUM_REGS - 1) ? SP_RESET : FILE_OPERAND_ALIAS_RESET;
         end
      end else begin
         regs_q <= regs_d;
      end
   end

   // all but stack pointer start uninitialized
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         init_q <= 16'h8000;
      end else begin
         init_q <= init_d;
      end
   end

   // ******************************************
   // Uninitialized pointer check
   // ******************************************
   // pointer use before word write
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         uninitRst_q <= 1'b0;
      end else begin
         uninitRst_q <= ptrUse & ~init_q[ptrAddr];
      end
   end

   // ******************************************
   // Read ports
   // ******************************************
   // Reads return value before this edge's writes
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rdDataA_q <= FILE_OPERAND_ALIAS_RESET;
         rdDataB_q <= FILE_OPERAND_ALIAS_RESET;
         ptrData_q <= FILE_OPERAND_ALIAS_RESET;
      end else begin
         rdDataA_q <= regs_q[rdIdxA];
         rdDataB_q <= regs_q[rdAddrB];
         ptrData_q <= regs_q[ptrAddr];
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         memRdata_q <= FILE_OPERAND_ALIAS_RESET;
         memHit_q <= 1'b0;
      end else begin
         memHit_q <= memHit;
         memRdata_q <= memHit ? regs_q[memIdx] : FILE_OPERAND_ALIAS_RESET;
      end
   end

   // ******************************************
   // Context save shadow
   // ******************************************
   // one level, save only path in
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < CTX_REGS; i++) begin
            shW_q[i] <= FILE_OPERAND_ALIAS_RESET;
         end
         shSt_q <= '0;
      end else if (ctxSave) begin
         for (int i = 0; i < CTX_REGS; i++) begin
            shW_q[i] <= regs_q[i];
         end
         shSt_q <= statusIn;
      end
   end

   // flags handed back with a load strobe
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         statusOut_q <= '0;
         statusLoad_q <= 1'b0;
      end else begin
         statusLoad_q <= ctxRestore;
         if (ctxRestore) begin
            statusOut_q <= shSt_q;
         end
      end
   end

   // ******************************************
   // Loop shadow
   // ******************************************
   wrfs_loop_if lp ();

   assign lp.saveStb = loopDoExec;
   assign lp.restoreStb = loopDoExit;
   assign lp.curStart = loopStartAddrIn;
   assign lp.curEnd = loopEndAddrIn;
   assign lp.curCount = loopIterCountIn;
   assign loopStartAddrSh = lp.shStart;
   assign loopEndAddrSh = lp.shEnd;
   assign loopIterCountSh = lp.shCount;
   assign loopRestoreVld = lp.restoreVld;

   wrfs_loop_shadow u_loop (
      .mclk(mclk),
      .arst_n(arst_n),
      .lp(lp)
   );

   // ******************************************
   // Checks
   // ******************************************
   logic postRst_q;
   logic quietWr;

   // Helper marks the first edge after release
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         postRst_q <= 1'b0;
      end else begin
         postRst_q <= 1'b1;
      end
   end

   assign quietWr = !memWr && !ctxRestore;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);

   a_sp_bit_zero: assert property (
      regs_q[SP_IDX][0] == 1'b0)
      else $error("stack pointer bit zero set");

   a_reset_values: assert property (
      !postRst_q |-> regs_q[SP_IDX] == SP_RESET && regs_q[1] == FILE_OPERAND_ALIAS_RESET
         && init_q == 16'h8000)
      else $error("wrong values after reset");

   a_file_reg_zero: assert property (
      wrEn && wrSel == WRFS_FILE && !wrByte && quietWr
         |=> regs_q[0] == $past(wrData))
      else $error("file write missed register zero");

   a_store_dominates: assert property (
      memWr && memWord && ptrUpdEn && ptrAddr == memIdx
         && memIdx != SP_IDX
         |=> regs_q[$past(memIdx)] == $past(memWdata))
      else $error("pointer update beat data store");

   a_byte_keeps_high: assert property (
      wrEn && wrByte && !memWr && !ptrUpdEn && !ctxRestore
         |=> regs_q[$past(wrIdx)][15:8] == $past(regs_q[wrIdx][15:8]))
      else $error("byte write changed high byte");

   a_byte_no_init: assert property (
      wrEn && wrByte && !memWr && !ptrUpdEn && !ctxRestore
         |=> init_q == $past(init_q))
      else $error("byte write changed init state");

   a_mapped_word_init: assert property (
      memWr && memWord |=> init_q[$past(memIdx)])
      else $error("mapped word write left register uninit");

   a_uninit_reset: assert property (
      ptrUse && !init_q[ptrAddr] |=> uninitRst_q)
      else $error("uninit pointer gave no reset");

   a_ctx_save_copy: assert property (
      ctxSave |=> shW_q[3] == $past(regs_q[3])
         && shSt_q == $past(statusIn))
      else $error("context save did not copy");

   a_ctx_restore: assert property (
      ctxRestore && !ctxSave && !wrEn && !memWr
         |=> regs_q[1] == $past(shW_q[1]) && statusLoad_q
         && statusOut_q == $past(shSt_q))
      else $error("context restore wrong");

   a_mapped_reg_two: assert property (
      memEn && !memWe && memAddr == WORKING_REGISTER_TWO_OFFSET
         |=> memHit_q && memRdata_q == $past(regs_q[2]))
      else $error("address of register two not mapped");

endmodule

// ===== tb/wrfs_core_model.sv
// Purpose: Core-side reset logic answering the register file
// Assumes: uninitRst_q is a one-cycle request on mclk
// Notes: Request is stretched so every flop sees the reset
module wrfs_core_model (
   input wire logic mclk,
   input wire logic porRst_n,
   input wire logic uninitRst_q,
   output logic arst_n
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [1:0] rstCnt_q;
   always_ff @(posedge mclk or negedge porRst_n) begin
      if (!porRst_n) begin
         rstCnt_q <= 2'h0;
      end else if (uninitRst_q) begin
         rstCnt_q <= 2'h3;
      end else if (rstCnt_q != 2'h0) begin
         rstCnt_q <= rstCnt_q - 2'h1;
      end
   end
   // Counter itself survives, so the pulse cannot cut itself short
   assign arst_n = porRst_n && (rstCnt_q == 2'h0);
endmodule

// ===== tb/wrfs_regfile_test.sv
// Purpose: Self-checking bench of the working register file
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Uninitialized pointer use resets the block through the model
module wrfs_regfile_test
   import wrfs_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic mclk = 1'b0, porRst_n = 1'b0, arst_n;
   logic [3:0] rdAddrA = 4'h0, rdAddrB = 4'h0, wrAddr = 4'h0, ptrAddr = 4'h0;
   wrfs_sel_t rdSelA = WRFS_DIRECT, wrSel = WRFS_DIRECT;
   logic wrEn = 1'b0, wrByte = 1'b0, ptrUse = 1'b0, ptrUpdEn = 1'b0;
   logic memEn = 1'b0, memWe = 1'b0, ctxSave = 1'b0, ctxRestore = 1'b0;
   logic loopDoExec = 1'b0, loopDoExit = 1'b0;
   logic [1:0] memBe = 2'h0;
   logic [4:0] statusIn = 5'h00, statusOut_q;
   logic [15:0] wrData = 16'h0000, ptrUpdData = 16'h0000;
   logic [15:0] memAddr = 16'h0000, memWdata = 16'h0000;
   logic [15:0] loopStartAddrIn = 16'h0000, loopEndAddrIn = 16'h0000;
   logic [15:0] loopIterCountIn = 16'h0000;
   logic [15:0] rdDataA_q, rdDataB_q, ptrData_q, memRdata_q;
   logic [15:0] loopStartAddrSh, loopEndAddrSh, loopIterCountSh;
   logic uninitRst_q, memHit_q, statusLoad_q, loopRestoreVld;
   int n_errors = 0, total_checks = 0;

   always #2.5 mclk = ~mclk;

   wrfs_core_model core (.mclk, .porRst_n, .uninitRst_q, .arst_n);
   wrfs_regfile dut (.mclk, .arst_n, .rdAddrA, .rdSelA, .rdAddrB,
      .rdDataA_q, .rdDataB_q, .wrEn, .wrSel, .wrByte, .wrAddr, .wrData,
      .ptrUse, .ptrAddr, .ptrUpdEn, .ptrUpdData, .ptrData_q, .uninitRst_q,
      .memEn, .memWe, .memAddr, .memBe, .memWdata, .memRdata_q, .memHit_q,
      .ctxSave, .ctxRestore, .statusIn, .statusOut_q, .statusLoad_q,
      .loopDoExec, .loopDoExit, .loopStartAddrIn, .loopEndAddrIn,
      .loopIterCountIn, .loopStartAddrSh, .loopEndAddrSh, .loopIterCountSh,
      .loopRestoreVld);

   // ****************************************
   // Access and compare tasks
   // ****************************************
   task automatic chkW(input string nm, input logic [15:0] e, input logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chkB(input string nm, input logic e, input logic g);
      chkW(nm, {15'h0000, e}, {15'h0000, g});
   endtask
   task automatic tick;
      @(posedge mclk);
      #1;
   endtask
   task automatic done(input string nm);
      $display("test %s finished, mismatches so far %0d", nm, n_errors);
   endtask
   task automatic wr(input wrfs_sel_t s, input logic b, input logic [3:0] i,
         input logic [15:0] d);
      {wrEn, wrSel, wrByte, wrAddr, wrData} = {1'b1, s, b, i, d};
      tick;
      wrEn = 1'b0;
   endtask
   task automatic rdChk(input string nm, input wrfs_sel_t s,
         input logic [3:0] i, input logic [15:0] e);
      {rdSelA, rdAddrA, rdAddrB} = {s, i, i};
      tick;
      chkW(nm, e, rdDataA_q);
      if (s == WRFS_DIRECT) chkW(nm, e, rdDataB_q);
   endtask
   task automatic mem(input logic w, input logic [15:0] a, input logic [1:0] b,
         input logic [15:0] d);
      {memEn, memWe, memAddr, memBe, memWdata} = {1'b1, w, a, b, d};
      tick;
      {memEn, memWe} = 2'b00;
   endtask
   task automatic ptr(input logic [3:0] i, input logic e, input logic [15:0] d);
      {ptrUse, ptrAddr} = {1'b1, i};
      tick;
      ptrUse = 1'b0;
      chkB("uninitRst_q", e, uninitRst_q);
      chkW("ptrData_q", d, ptrData_q);
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   function automatic logic [15:0] val(input logic [3:0] i);
      return {i, 4'hA, ~i, 4'h5};
   endfunction

   // ****************************************
   // Test sequence
   // ****************************************
   initial begin
      repeat (12) tick;
      porRst_n = 1'b1;
      for (int i = 0; i < 16; i++)
         rdChk("reset", WRFS_DIRECT, 4'(i), (i == 15) ? SP_RESET : FILE_OPERAND_ALIAS_RESET);
      ptr(SP_IDX, 1'b0, SP_RESET);
      done("reset");
      wr(WRFS_DIRECT, 1'b0, 4'h3, 16'h3333);
      ptr(4'h3, 1'b0, 16'h3333);
      wr(WRFS_DIRECT, 1'b1, 4'h6, 16'h00C3);
      ptr(4'h6, 1'b1, 16'h00C3);
      repeat (6) tick;
      rdChk("clearedReg", WRFS_DIRECT, 4'h3, 16'h0000);
      mem(1'b1, 16'h000E, 2'h3, 16'h1234);
      ptr(4'h7, 1'b0, 16'h1234);
      done("init");
      for (int i = 0; i < 16; i++) wr(WRFS_DIRECT, 1'b0, 4'(i), val(4'(i)));
      for (int i = 0; i < 16; i++)
         rdChk("word", WRFS_DIRECT, 4'(i), val(4'(i)) & ((i == 15) ? 16'hFFFE : 16'hFFFF));
      wr(WRFS_FILE, 1'b0, 4'h5, 16'hBEEF);
      rdChk("fileReg0", WRFS_DIRECT, FILE_IDX, 16'hBEEF);
      rdChk("reg5", WRFS_DIRECT, 4'h5, val(4'h5));
      rdChk("fileRead", WRFS_FILE, 4'h9, 16'hBEEF);
      wr(WRFS_DIRECT, 1'b1, 4'h4, 16'h7733);
      rdChk("byteWr", WRFS_DIRECT, 4'h4, {val(4'h4) & 16'hFF00} | 16'h0033);
      done("array");
      mem(1'b1, WORKING_REGISTER_TWO_OFFSET, 2'h3, 16'h2222);
      chkB("memHit_q", 1'b1, memHit_q);
      rdChk("mappedWr", WRFS_DIRECT, 4'h2, 16'h2222);
      mem(1'b1, WORKING_REGISTER_TWO_OFFSET, 2'h2, 16'h5500);
      mem(1'b1, WORKING_REGISTER_TWO_OFFSET, 2'h1, 16'hAA66);
      mem(1'b0, WORKING_REGISTER_TWO_OFFSET, 2'h3, 16'h0000);
      chkW("laneWr", 16'h5566, memRdata_q);
      mem(1'b0, 16'h001E, 2'h3, 16'h0000);
      chkW("mappedSp", 16'hFA04, memRdata_q);
      mem(1'b1, 16'h0020, 2'h3, 16'hDEAD);
      chkB("missHit", 1'b0, memHit_q);
      chkW("missData", 16'h0000, memRdata_q);
      rdChk("missNoWr", WRFS_DIRECT, 4'h0, 16'hBEEF);
      {ptrUpdEn, ptrAddr, ptrUpdData} = {1'b1, 4'h2, 16'h0006};
      mem(1'b1, WORKING_REGISTER_TWO_OFFSET, 2'h3, 16'h1234);
      ptrUpdEn = 1'b0;
      rdChk("collide", WRFS_DIRECT, 4'h2, 16'h1234);
      done("mapped");
      {loopStartAddrIn, loopEndAddrIn, loopIterCountIn} = 48'h0100_0180_0007;
      loopDoExec = 1'b1;
      tick;
      {loopStartAddrIn, loopEndAddrIn, loopIterCountIn} = 48'h0200_0280_0003;
      tick;
      loopDoExec = 1'b0;
      chkW("loopSh", 16'h0280, loopEndAddrSh);
      chkW("loopSh", 16'h0003, loopIterCountSh);
      loopDoExit = 1'b1;
      tick;
      loopDoExit = 1'b0;
      chkB("loopRestoreVld", 1'b1, loopRestoreVld);
      tick;
      chkB("loopRestoreVld", 1'b0, loopRestoreVld);
      done("loop");
      {ctxSave, statusIn} = {1'b1, 5'h15};
      tick;
      for (int i = 0; i < 4; i++) wr(WRFS_DIRECT, 1'b0, 4'(i), 16'h0F00 + 16'(i));
      {ctxSave, statusIn} = {1'b1, 5'h0A};
      tick;
      ctxSave = 1'b0;
      for (int i = 0; i < 5; i++) wr(WRFS_DIRECT, 1'b0, 4'(i), 16'h9000 + 16'(i));
      ctxRestore = 1'b1;
      tick;
      ctxRestore = 1'b0;
      chkB("statusLoad_q", 1'b1, statusLoad_q);
      chkW("statusOut_q", 16'h000A, {11'h000, statusOut_q});
      for (int i = 0; i < 4; i++)
         rdChk("restore", WRFS_DIRECT, 4'(i), 16'h0F00 + 16'(i));
      chkB("statusLoad_q", 1'b0, statusLoad_q);
      rdChk("reg4Kept", WRFS_DIRECT, 4'h4, 16'h9004);
      chkW("loopShKept", 16'h0200, loopStartAddrSh);
      done("context");
      wrap_up;
   end

   initial begin
      repeat (20000) @(posedge mclk);
      $display("run stalled, stopping");
      n_errors++;
      wrap_up;
   end
endmodule
